// ===== hdl/psr_defines.vh
// Shared constants of the platform system register bank
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH

// ==================================================
// Register byte offsets
`define PSR_OFS_IDENTITY 8'h00
`define PSR_OFS_SWITCH 8'h04
`define PSR_OFS_LIGHT 8'h08
`define PSR_OFS_SLOW_TICK 8'h24
`define PSR_OFS_FLAG_SET 8'h30
`define PSR_OFS_FLAG_CLR 8'h34
`define PSR_OFS_PFLAG_SET 8'h38
`define PSR_OFS_PFLAG_CLR 8'h3C
`define PSR_OFS_CARD 8'h48
`define PSR_OFS_FLASH 8'h4C
`define PSR_OFS_BOOT_SEL 8'h58
`define PSR_OFS_FAST_TICK 8'h5C
`define PSR_OFS_MISC 8'h60
`define PSR_OFS_XFER_MAP 8'h64
`define PSR_OFS_PROC_ID0 8'h84
`define PSR_OFS_PROC_ID3 8'h90
`define PSR_OFS_CFG_DATA 8'hA0
`define PSR_OFS_CFG_CTRL 8'hA4
`define PSR_OFS_CFG_STAT 8'hA8
`define PSR_OFS_DISP_SITE 8'hB0

// ==================================================
// Field layouts
`define PSR_USER_BITS 8
`define PSR_CTRL_START 31
`define PSR_CTRL_WRITE 30
`define PSR_CTRL_SEL_MSB 29
`define PSR_STAT_DONE 0
`define PSR_STAT_ERR 1
`define PSR_STAT_BUSY 2
`define PSR_SITE_W 2

// ==================================================
// Display source site encodings
`define PSR_SITE_MAIN 2'h0
`define PSR_SITE_DB1 2'h1
`define PSR_SITE_DB2 2'h2

// ==================================================
// Reset values, responses, rates
`define PSR_ZERO32 32'h0000_0000
`define PSR_IDENT_DEFAULT 32'h5A5A_0001
`define PSR_RESP_OKAY 2'h0
`define PSR_RESP_SLVERR 2'h2
`define PSR_CLK_HZ 20000000
`define PSR_SLOW_HZ 100
`define PSR_FAST_HZ 24000000

`endif

// ===== hdl/psr_tick_counter.v
// Free-running counter that advances at a set rate from the bus clock
`timescale 1ns/1ps
`include "psr_defines.vh"
module psr_tick_counter #(
	parameter CLK_HZ = `PSR_CLK_HZ,
	parameter RATE_HZ = `PSR_SLOW_HZ
)(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Count
	output reg [31:0] count_ff
);
	// Whole steps per clock and the fractional remainder in clock units
	localparam [31:0] STEP_WHOLE = RATE_HZ / CLK_HZ;
	localparam [31:0] STEP_FRAC = RATE_HZ % CLK_HZ;
	localparam [32:0] CLK_LIMIT = CLK_HZ;

	reg [31:0] phase_ff;
	wire [32:0] phase_sum;
	wire carry;
	reg [31:0] nxt_phase;

	assign phase_sum = {1'b0, phase_ff} + {1'b0, STEP_FRAC};
	assign carry = (phase_sum >= CLK_LIMIT);

	always @*
	begin
		if (carry)
			nxt_phase = phase_sum[31:0] - CLK_LIMIT[31:0];
		else
			nxt_phase = phase_sum[31:0];
	end

	// ==================================================
	// Counter wraps silently on overflow
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase_ff <= `PSR_ZERO32;
			count_ff <= `PSR_ZERO32;
		end
		else
		begin
			phase_ff <= nxt_phase;
			count_ff <= count_ff + STEP_WHOLE + {31'h0000_0000, carry};
		end
	end
endmodule

// ===== hdl/psr_register_bank.v
// Platform system register bank with AXI4-Lite slave
`timescale 1ns/1ps
`include "psr_defines.vh"

// Function
// - Switch readback register returns the eight user switch inputs in bits 7:0
// - Light register drives eight light outputs and reads back the written value
// - Read-only counter advancing at 100 Hz; writes leave it unchanged
// - Read-only counter advancing at 24 MHz; writes leave it unchanged
// - Writing the flag clear register clears selected flag bits only
// - Writing the persistent flag clear register clears selected persistent bits only
// - Software loads data, starts transfer by control; device reports progress in status
// - Display source site selects main, first or second daughterboard; default first
module psr_register_bank #(
	parameter CLK_HZ = `PSR_CLK_HZ,
	parameter SLOW_HZ = `PSR_SLOW_HZ,
	parameter FAST_HZ = `PSR_FAST_HZ,
	// Arbitrary identity value, names no real part
	parameter [31:0] IDENT_RESET = `PSR_IDENT_DEFAULT,
	parameter [1:0] DEFAULT_SITE = `PSR_SITE_DB1
)(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Board pins
	input wire [7:0] user_switch_bank,
	output wire [7:0] user_light_outputs,
	input wire [31:0] card_interface_status,
	output wire [31:0] flash_control,
	output wire [31:0] boot_select_switch,
	output wire [31:0] misc_control_flags,
	output wire [31:0] transfer_peripheral_map,
	output wire [1:0] default_display_source_site,
	// Board controller transfer port
	output reg cfg_req_ff,
	output reg cfg_write_ff,
	output reg [29:0] cfg_select_ff,
	output reg [31:0] cfg_wdata_ff,
	input wire cfg_ack,
	input wire cfg_err,
	input wire [31:0] cfg_rdata
);
	// ==================================================
	// Storage
	reg [31:0] ident_ff;
	reg [7:0] light_ff;
	reg [31:0] flag_ff;
	reg [31:0] pflag_ff;
	reg [31:0] flash_ff;
	reg [31:0] boot_sel_ff;
	reg [31:0] misc_ff;
	reg [31:0] xfer_map_ff;
	reg [31:0] proc_id_ff [0:3];
	reg [31:0] cfg_data_ff;
	reg [31:0] cfg_ctrl_ff;
	reg [1:0] cfg_stat_ff;
	reg [1:0] site_ff;
	wire [31:0] slow_count;
	wire [31:0] fast_count;

	// Bus state
	reg aw_held_ff;
	reg w_held_ff;
	reg [7:0] waddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	wire write_fire;
	wire [31:0] wmask;
	reg wr_hit;
	reg [31:0] rd_word;
	reg rd_hit;

	// ==================================================
	// Counters
	psr_tick_counter #(
		.CLK_HZ(CLK_HZ),
		.RATE_HZ(SLOW_HZ)
	) u_slow_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.count_ff(slow_count)
	);

	psr_tick_counter #(
		.CLK_HZ(CLK_HZ),
		.RATE_HZ(FAST_HZ)
	) u_fast_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.count_ff(fast_count)
	);

	// ==================================================
	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
	assign write_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			waddr_ff <= 8'h00;
			wdata_ff <= `PSR_ZERO32;
			wstrb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PSR_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				waddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (write_fire)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Which word addresses accept writes; read-only words answer OKAY and ignore data
	always @*
	begin
		wr_hit = 1'b1;
		if (waddr_ff[7:2] > `PSR_OFS_DISP_SITE >> 2)
			wr_hit = 1'b0;
		else if (rd_index_valid(waddr_ff))
			wr_hit = 1'b1;
		else
			wr_hit = 1'b0;
	end

	function rd_index_valid;
		input [7:0] a;
		reg [7:0] w;
		begin
			w = {a[7:2], 2'b00};
			rd_index_valid = (w == `PSR_OFS_IDENTITY) || (w == `PSR_OFS_SWITCH) || (w == `PSR_OFS_LIGHT)
				|| (w == `PSR_OFS_SLOW_TICK) || (w == `PSR_OFS_FLAG_SET) || (w == `PSR_OFS_FLAG_CLR)
				|| (w == `PSR_OFS_PFLAG_SET) || (w == `PSR_OFS_PFLAG_CLR) || (w == `PSR_OFS_CARD)
				|| (w == `PSR_OFS_FLASH) || (w == `PSR_OFS_BOOT_SEL) || (w == `PSR_OFS_FAST_TICK)
				|| (w == `PSR_OFS_MISC) || (w == `PSR_OFS_XFER_MAP)
				|| ((w >= `PSR_OFS_PROC_ID0) && (w <= `PSR_OFS_PROC_ID3))
				|| (w == `PSR_OFS_CFG_DATA) || (w == `PSR_OFS_CFG_CTRL) || (w == `PSR_OFS_CFG_STAT)
				|| (w == `PSR_OFS_DISP_SITE);
		end
	endfunction

	// ==================================================
	// Register updates
	wire [7:0] wword;
	wire [31:0] wmerge_flash;
	wire [31:0] wmasked;
	wire cfg_start;
	wire cfg_done;
	assign wword = {waddr_ff[7:2], 2'b00};
	assign wmasked = wdata_ff & wmask;
	assign wmerge_flash = (flash_ff & ~wmask) | wmasked;
	assign cfg_start = cfg_ctrl_ff[`PSR_CTRL_START] && !cfg_req_ff;
	assign cfg_done = cfg_req_ff && cfg_ack;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ident_ff <= IDENT_RESET;
			light_ff <= 8'h00;
			flag_ff <= `PSR_ZERO32;
			pflag_ff <= `PSR_ZERO32;
			flash_ff <= `PSR_ZERO32;
			boot_sel_ff <= `PSR_ZERO32;
			misc_ff <= `PSR_ZERO32;
			xfer_map_ff <= `PSR_ZERO32;
			proc_id_ff[0] <= `PSR_ZERO32;
			proc_id_ff[1] <= `PSR_ZERO32;
			proc_id_ff[2] <= `PSR_ZERO32;
			proc_id_ff[3] <= `PSR_ZERO32;
			site_ff <= DEFAULT_SITE;
		end
		else if (write_fire)
		begin
			if (wword == `PSR_OFS_IDENTITY)
				ident_ff <= (ident_ff & ~wmask) | wmasked;
			else if (wword == `PSR_OFS_LIGHT)
				light_ff <= wstrb_ff[0] ? wdata_ff[7:0] : light_ff;
			else if (wword == `PSR_OFS_FLAG_SET)
				flag_ff <= flag_ff | wmasked;
			else if (wword == `PSR_OFS_FLAG_CLR)
				flag_ff <= flag_ff & ~wmasked;
			else if (wword == `PSR_OFS_PFLAG_SET)
				pflag_ff <= pflag_ff | wmasked;
			else if (wword == `PSR_OFS_PFLAG_CLR)
				pflag_ff <= pflag_ff & ~wmasked;
			else if (wword == `PSR_OFS_FLASH)
				flash_ff <= wmerge_flash;
			else if (wword == `PSR_OFS_BOOT_SEL)
				boot_sel_ff <= (boot_sel_ff & ~wmask) | wmasked;
			else if (wword == `PSR_OFS_MISC)
				misc_ff <= (misc_ff & ~wmask) | wmasked;
			else if (wword == `PSR_OFS_XFER_MAP)
				xfer_map_ff <= (xfer_map_ff & ~wmask) | wmasked;
			else if ((wword >= `PSR_OFS_PROC_ID0) && (wword <= `PSR_OFS_PROC_ID3))
				proc_id_ff[wword[3:2] - 2'h1] <= (proc_id_ff[wword[3:2] - 2'h1] & ~wmask) | wmasked;
			else if (wword == `PSR_OFS_DISP_SITE)
			begin
				// Undefined code 3 is refused so the output always names a real site
				if (wstrb_ff[0] && (wdata_ff[1:0] <= `PSR_SITE_DB2))
					site_ff <= wdata_ff[1:0];
			end
		end
	end

	// ==================================================
	// Board controller transfer
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_data_ff <= `PSR_ZERO32;
			cfg_ctrl_ff <= `PSR_ZERO32;
			cfg_stat_ff <= 2'h0;
			cfg_req_ff <= 1'b0;
			cfg_write_ff <= 1'b0;
			cfg_select_ff <= 30'h0000_0000;
			cfg_wdata_ff <= `PSR_ZERO32;
		end
		else
		begin
			// Request stays up until the controller acknowledges
			if (cfg_start)
			begin
				cfg_req_ff <= 1'b1;
				cfg_write_ff <= cfg_ctrl_ff[`PSR_CTRL_WRITE];
				cfg_select_ff <= cfg_ctrl_ff[`PSR_CTRL_SEL_MSB:0];
				cfg_wdata_ff <= cfg_data_ff;
				cfg_ctrl_ff[`PSR_CTRL_START] <= 1'b0;
			end
			else if (cfg_done)
				cfg_req_ff <= 1'b0;

			if (write_fire && (wword == `PSR_OFS_CFG_CTRL) && !cfg_req_ff && !cfg_start)
			begin
				cfg_ctrl_ff <= (cfg_ctrl_ff & ~wmask) | wmasked;
				if (wmasked[`PSR_CTRL_START])
					cfg_stat_ff <= 2'h0;
			end

			// Read data returned by the controller beats a software write in the same cycle
			if (cfg_done && !cfg_write_ff)
				cfg_data_ff <= cfg_rdata;
			else if (write_fire && (wword == `PSR_OFS_CFG_DATA) && !cfg_req_ff)
				cfg_data_ff <= (cfg_data_ff & ~wmask) | wmasked;

			// Completion sets win over a software clear of the status word
			if (cfg_done)
			begin
				cfg_stat_ff[`PSR_STAT_DONE] <= 1'b1;
				cfg_stat_ff[`PSR_STAT_ERR] <= cfg_err;
			end
			else if (write_fire && (wword == `PSR_OFS_CFG_STAT) && wstrb_ff[0])
				cfg_stat_ff <= wdata_ff[1:0];
		end
	end

	// ==================================================
	// Read channel
	assign s_axi_arready = !s_axi_rvalid;

	always @*
	begin
		rd_word = `PSR_ZERO32;
		rd_hit = 1'b1;
		if (s_axi_araddr[7:2] == `PSR_OFS_IDENTITY >> 2)
			rd_word = ident_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_SWITCH >> 2)
			rd_word = {24'h00_0000, user_switch_bank};
		else if (s_axi_araddr[7:2] == `PSR_OFS_LIGHT >> 2)
			rd_word = {24'h00_0000, light_ff};
		else if (s_axi_araddr[7:2] == `PSR_OFS_SLOW_TICK >> 2)
			rd_word = slow_count;
		else if (s_axi_araddr[7:2] == `PSR_OFS_FLAG_SET >> 2)
			rd_word = flag_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_PFLAG_SET >> 2)
			rd_word = pflag_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_CARD >> 2)
			rd_word = card_interface_status;
		else if (s_axi_araddr[7:2] == `PSR_OFS_FLASH >> 2)
			rd_word = flash_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_BOOT_SEL >> 2)
			rd_word = boot_sel_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_FAST_TICK >> 2)
			rd_word = fast_count;
		else if (s_axi_araddr[7:2] == `PSR_OFS_MISC >> 2)
			rd_word = misc_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_XFER_MAP >> 2)
			rd_word = xfer_map_ff;
		else if ((s_axi_araddr[7:2] >= `PSR_OFS_PROC_ID0 >> 2) && (s_axi_araddr[7:2] <= `PSR_OFS_PROC_ID3 >> 2))
			rd_word = proc_id_ff[s_axi_araddr[3:2] - 2'h1];
		else if (s_axi_araddr[7:2] == `PSR_OFS_CFG_DATA >> 2)
			rd_word = cfg_data_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_CFG_CTRL >> 2)
			rd_word = cfg_ctrl_ff;
		else if (s_axi_araddr[7:2] == `PSR_OFS_CFG_STAT >> 2)
			rd_word = {29'h0000_0000, cfg_req_ff, cfg_stat_ff};
		else if (s_axi_araddr[7:2] == `PSR_OFS_DISP_SITE >> 2)
			rd_word = {30'h0000_0000, site_ff};
		else if ((s_axi_araddr[7:2] == `PSR_OFS_FLAG_CLR >> 2) || (s_axi_araddr[7:2] == `PSR_OFS_PFLAG_CLR >> 2))
			rd_word = `PSR_ZERO32;
		else
			rd_hit = 1'b0;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `PSR_ZERO32;
			s_axi_rresp <= `PSR_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==================================================
	// Board outputs
	assign user_light_outputs = light_ff;
	assign flash_control = flash_ff;
	assign boot_select_switch = boot_sel_ff;
	assign misc_control_flags = misc_ff;
	assign transfer_peripheral_map = xfer_map_ff;
	assign default_display_source_site = site_ff;
endmodule

// ===== tb/psr_register_bank_props.sv
// Bus and pin assertions for the platform system register bank
`timescale 1ns/1ps
module psr_register_bank_props (
	// Clock and reset
	input logic aclk,
	input logic aresetn,
	// Register bus
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	// Board pins
	input logic [7:0] user_light_outputs,
	input logic [1:0] default_display_source_site,
	input logic cfg_req_ff,
	input logic [29:0] cfg_select_ff,
	input logic [31:0] cfg_wdata_ff,
	input logic cfg_ack
);
	// ==================================================
	// Properties
	wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_after_w; wr_take |=> ##1 s_axi_bvalid; endproperty
	property p_w_blocked; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_r_after_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_ar_blocked; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_light; wr_take && s_axi_awaddr[7:2] == 6'h02 && s_axi_wstrb[0]
		|=> ##1 user_light_outputs == $past(s_axi_wdata[7:0], 2); endproperty
	property p_reset_pins; $rose(aresetn) |-> default_display_source_site == 2'h1 && user_light_outputs == 8'h00;
	endproperty
	property p_site_legal; default_display_source_site != 2'h3; endproperty
	property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000; endproperty
	property p_cfg_hold; cfg_req_ff && !cfg_ack
		|=> cfg_req_ff && $stable(cfg_select_ff) && $stable(cfg_wdata_ff); endproperty
	property p_cfg_done; cfg_req_ff && cfg_ack |=> !cfg_req_ff; endproperty
	// ==================================================
	// Assertions and covers
	a_b_after_w: assert property (p_b_after_w) else $error("write response late");
	a_w_blocked: assert property (p_w_blocked) else $error("write taken during response");
	a_r_after_ar: assert property (p_r_after_ar) else $error("read data late");
	a_ar_blocked: assert property (p_ar_blocked) else $error("read taken during data");
	a_light: assert property (p_light) else $error("light pins wrong after write");
	a_reset_pins: assert property (p_reset_pins) else $error("pin values wrong after reset");
	a_site_legal: assert property (p_site_legal) else $error("site code out of range");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	a_cfg_hold: assert property (p_cfg_hold) else $error("transfer request dropped early");
	a_cfg_done: assert property (p_cfg_done) else $error("transfer request held after ack");
	c_cfg: cover property (cfg_req_ff && cfg_ack);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_light: cover property (wr_take && s_axi_awaddr[7:2] == 6'h02);
endmodule

bind psr_register_bank psr_register_bank_props u_props (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .user_light_outputs, .default_display_source_site,
	.cfg_req_ff, .cfg_select_ff, .cfg_wdata_ff, .cfg_ack
);

// ===== tb/tb_psr_register_bank.sv
// Self-checking testbench for the platform system register bank
`timescale 1ns/1ps
`include "psr_defines.vh"
module tb_psr_register_bank;
	logic aclk, aresetn, awv, wv, bready, arv, rready, cfg_ack, cfg_err;
	logic [7:0] awaddr, araddr, sw, fa;
	logic [31:0] wdata, card, cfg_rdata, d, v1, v2;
	logic [3:0] wstrb;
	wire awready, wready, bvalid, arready, rvalid, cfg_req, cfg_write;
	wire [1:0] bresp, rresp, site;
	wire [31:0] rdata, cfg_wdata;
	wire [7:0] lights;
	wire [29:0] cfg_sel;
	wire [31:0] flash_pins, boot_pins, misc_pins, map_pins;
	int fails, n_compared, cyc, t1, t2, i, dv;
	logic [33:0] er[$];
	logic [1:0] eb[$];

	// Slow tick every 10 clocks keeps the rate check short
	psr_register_bank #(.SLOW_HZ(2000000)) u_psr_register_bank (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.user_switch_bank(sw), .user_light_outputs(lights), .card_interface_status(card),
		.flash_control(flash_pins), .boot_select_switch(boot_pins), .misc_control_flags(misc_pins),
		.transfer_peripheral_map(map_pins),
		.default_display_source_site(site), .cfg_req_ff(cfg_req), .cfg_write_ff(cfg_write),
		.cfg_select_ff(cfg_sel), .cfg_wdata_ff(cfg_wdata), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
		.cfg_rdata(cfg_rdata)
	);

	// ==================================================
	// Reporting
	task chk(string nm, logic [63:0] seen, logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==================================================
	// Bus master; ready lines stay high, so every answer is taken at once
	task wr(input [7:0] a, input [31:0] dd, input [1:0] r);
		logic pa, pw;
		eb.push_back(r);
		awaddr <= a;
		wdata <= dd;
		awv <= 1'b1;
		wv <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw)
		begin
			@(posedge aclk);
			pa = pa && !awready;
			pw = pw && !wready;
			awv <= pa;
			wv <= pw;
		end
		do @(posedge aclk); while (!bvalid);
	endtask

	task rd(input [7:0] a, input [33:0] e, input bit c);
		if (c)
			er.push_back(e);
		araddr <= a;
		arv <= 1'b1;
		do @(posedge aclk); while (!arready);
		arv <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		v2 = rdata;
		t2 = cyc;
	endtask

	// ==================================================
	// Clock, watchdog and response monitor
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails++;
			finish_test();
		end
	end

	always @(posedge aclk)
	begin
		if (bvalid && bready)
			chk("bresp", {32'h0, bresp}, {32'h0, eb.pop_front()});
		if (rvalid && rready && er.size() > 0)
			chk("rdata", {rresp, rdata}, er.pop_front());
	end

	// ==================================================
	// Scenarios
	initial
	begin
		{aresetn, awv, wv, arv, cfg_ack, cfg_err, awaddr, araddr, wdata} = '0;
		{bready, rready, wstrb, fails, n_compared, cyc} = {6'h3F, 96'h0};
		sw = $urandom(8887);
		card = $urandom;
		cfg_rdata = $urandom;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("site", site, `PSR_SITE_DB1);
		chk("lights", lights, 8'h00);
		// Less than one slow period has passed since reset
		rd(`PSR_OFS_SLOW_TICK, 34'h0, 1);
		rd(`PSR_OFS_IDENTITY, {2'h0, `PSR_IDENT_DEFAULT}, 1);
		rd(`PSR_OFS_DISP_SITE, 34'h1, 1);
		wr(`PSR_OFS_SWITCH, 32'hFFFF_FFFF, `PSR_RESP_OKAY);
		rd(`PSR_OFS_SWITCH, {26'h0, sw}, 1);
		rd(`PSR_OFS_CARD, {2'h0, card}, 1);
		d = $urandom;
		wr(`PSR_OFS_LIGHT, d, `PSR_RESP_OKAY);
		chk("lights", lights, d[7:0]);
		rd(`PSR_OFS_LIGHT, {26'h0, d[7:0]}, 1);
		// Plain read-write words: distinct values catch a wrong word index
		for (i = 0; i < 4; i++)
		begin
			fa = `PSR_OFS_PROC_ID0 + 8'(4 * i);
			wr(fa, 32'h1111_1111 * (i + 1), `PSR_RESP_OKAY);
		end
		for (i = 0; i < 4; i++)
		begin
			fa = `PSR_OFS_PROC_ID0 + 8'(4 * i);
			rd(fa, {2'h0, 32'h1111_1111 * (i + 1)}, 1);
		end
		wr(`PSR_OFS_IDENTITY, ~d, `PSR_RESP_OKAY);
		rd(`PSR_OFS_IDENTITY, {2'h0, ~d}, 1);
		wr(`PSR_OFS_FLASH, d, `PSR_RESP_OKAY);
		wr(`PSR_OFS_BOOT_SEL, ~d, `PSR_RESP_OKAY);
		wr(`PSR_OFS_MISC, {d[15:0], d[31:16]}, `PSR_RESP_OKAY);
		wr(`PSR_OFS_XFER_MAP, d ^ 32'h5A5A_A5A5, `PSR_RESP_OKAY);
		chk("pins", {flash_pins, boot_pins}, {d, ~d});
		chk("pins", {misc_pins, map_pins}, {d[15:0], d[31:16], d ^ 32'h5A5A_A5A5});
		rd(`PSR_OFS_FLASH, {2'h0, d}, 1);
		rd(`PSR_OFS_BOOT_SEL, {2'h0, ~d}, 1);
		rd(`PSR_OFS_MISC, {2'h0, d[15:0], d[31:16]}, 1);
		rd(`PSR_OFS_XFER_MAP, {2'h0, d ^ 32'h5A5A_A5A5}, 1);
		for (i = 0; i < 2; i++)
		begin
			fa = i ? `PSR_OFS_PFLAG_SET : `PSR_OFS_FLAG_SET;
			d = $urandom;
			wr(fa, d, `PSR_RESP_OKAY);
			wr(fa + 8'h04, 32'h0F0F_F0F0, `PSR_RESP_OKAY);
			rd(fa, {2'h0, d & 32'hF0F0_0F0F}, 1);
			rd(fa + 8'h04, 34'h0, 1);
		end
		// Code 3 is not a site, so the previous choice must survive it
		for (i = 0; i < 4; i++)
		begin
			wr(`PSR_OFS_DISP_SITE, i, `PSR_RESP_OKAY);
			chk("site", site, i < 3 ? i : 2);
		end
		wr(8'h10, 32'h1, `PSR_RESP_SLVERR);
		rd(8'h10, {`PSR_RESP_SLVERR, 32'h0}, 1);
		for (i = 0; i < 2; i++)
		begin
			fa = i ? `PSR_OFS_FAST_TICK : `PSR_OFS_SLOW_TICK;
			rd(fa, 34'h0, 0);
			v1 = v2;
			t1 = t2;
			wr(fa, 32'h0, `PSR_RESP_OKAY);
			repeat (40) @(posedge aclk);
			rd(fa, 34'h0, 0);
			dv = v2 - v1;
			chk("rate", (i ? 5 * dv - 6 * (t2 - t1) : 10 * dv - (t2 - t1)) inside {[-10:10]}, 1'b1);
		end
		// Write transfer ending in error; data and start writes while busy are dropped
		d = $urandom;
		wr(`PSR_OFS_CFG_DATA, d, `PSR_RESP_OKAY);
		wr(`PSR_OFS_CFG_CTRL, 32'hC000_0005, `PSR_RESP_OKAY);
		do @(posedge aclk); while (!cfg_req);
		chk("cfg", {cfg_write, cfg_sel, cfg_wdata}, {1'b1, 30'h5, d});
		wr(`PSR_OFS_CFG_DATA, ~d, `PSR_RESP_OKAY);
		wr(`PSR_OFS_CFG_CTRL, 32'h8000_0001, `PSR_RESP_OKAY);
		rd(`PSR_OFS_CFG_STAT, 34'h4, 1);
		cfg_err <= 1'b1;
		cfg_ack <= 1'b1;
		@(posedge aclk);
		cfg_ack <= 1'b0;
		rd(`PSR_OFS_CFG_STAT, 34'h3, 1);
		rd(`PSR_OFS_CFG_DATA, {2'h0, d}, 1);
		// Read transfer loads the answer into the data word
		wr(`PSR_OFS_CFG_CTRL, 32'h8000_0002, `PSR_RESP_OKAY);
		do @(posedge aclk); while (!cfg_req);
		chk("cfg", cfg_write, 1'b0);
		cfg_err <= 1'b0;
		cfg_ack <= 1'b1;
		@(posedge aclk);
		cfg_ack <= 1'b0;
		rd(`PSR_OFS_CFG_DATA, {2'h0, cfg_rdata}, 1);
		rd(`PSR_OFS_CFG_STAT, 34'h1, 1);
		finish_test();
	end
endmodule
